// ===== rtl/gpio_defs.svh
//
// Purpose: Register offsets, field positions and reset values for the GPIO port
// Assumes: Included by bare name from design files
// Notes:   Definitions only
//
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

`define REG_CH1_DATA      12'h000
`define REG_CH1_HIZ       12'h004
`define REG_CH2_DATA      12'h008
`define REG_CH2_HIZ       12'h00C
`define REG_GLOBAL_IRQ_EN 12'h11C
`define REG_IRQ_STATUS    12'h120
`define REG_IRQ_ENABLE    12'h128
`define ADDR_BITS         12
`define IRQ_GLOBAL_BIT    31
`define IRQ_CH1_BIT       0
`define IRQ_CH2_BIT       1
`define MAX_WIDTH         32
`define RESET_OUT_DEFAULT 32'h00000000
`define RESET_HIZ_DEFAULT 32'hFFFFFFFF

`endif

// ===== rtl/gpio_pkg.sv
//
// Purpose: Shared types for the GPIO port
// Assumes: Header gpio_defs.svh supplies the numbers
// Notes:   Types only
//
`include "gpio_defs.svh"

package gpio_pkg;

  typedef logic [31:0]             word_t;
  typedef logic [`ADDR_BITS-1:0]   addr_t;
  typedef logic [`MAX_WIDTH-1:0]   pins_t;

endpackage

// ===== rtl/gpio_chan_if.sv
//
// Purpose: Carries one channel's register state between the top and a channel
// Assumes: Single clock domain
// Notes:   Top drives write strobes, channel returns pin state
//
`timescale 1ns/100ps
`default_nettype none

interface gpio_chan_if;
  import gpio_pkg::*;

  logic  wr_data;
  logic  wr_hiz;
  word_t wdata;
  word_t rd_data;
  word_t rd_hiz;
  logic  edge_seen;

  modport ctrl
  (
    output wr_data,
    output wr_hiz,
    output wdata,
    input  rd_data,
    input  rd_hiz,
    input  edge_seen
  );

  modport chan
  (
    input  wr_data,
    input  wr_hiz,
    input  wdata,
    output rd_data,
    output rd_hiz,
    output edge_seen
  );

endinterface

`default_nettype wire

// ===== rtl/gpio_channel.sv
//
// Purpose: One GPIO channel: data and direction registers, input sync, change detect
// Assumes: pclk domain; pins_in is asynchronous
// Notes:   Unused channel is built with ENABLE = 0 and holds reset state
//
`timescale 1ns/100ps
`default_nettype none

`include "gpio_defs.svh"

module gpio_channel
#(
  parameter int                   WIDTH       = 32,
  parameter bit                   ENABLE      = 1'b1,
  parameter logic [`MAX_WIDTH-1:0] OUT_DEFAULT = `RESET_OUT_DEFAULT,
  parameter logic [`MAX_WIDTH-1:0] HIZ_DEFAULT = `RESET_HIZ_DEFAULT
)
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Register side
  gpio_chan_if.chan             regs,
  // Pins
  input  wire logic [WIDTH-1:0] pins_in,
  output var  logic [WIDTH-1:0] pins_out,
  output var  logic [WIDTH-1:0] pins_hiz
);
  import gpio_pkg::*;

  // Refuse widths the 32-bit register word cannot carry
  if (WIDTH < 1 || WIDTH > `MAX_WIDTH)
  begin
    $error("channel width must be 1 to 32");
  end

  typedef struct packed {
    logic [WIDTH-1:0] sync1;
    logic [WIDTH-1:0] sync2;
    logic [WIDTH-1:0] last;
    logic [WIDTH-1:0] out;
    logic [WIDTH-1:0] hiz;
    logic [1:0]       warm;
    logic             edge_seen;
  } chan_s;

  chan_s cur;
  chan_s next_cur;

  always_comb
  begin
    next_cur           = cur;
    next_cur.sync1     = pins_in;
    next_cur.sync2     = cur.sync1;
    next_cur.last      = cur.sync2;
    // Compare only synchronised samples; sync1 may be metastable
    // Hold off change detect until the chain holds real pin samples; else the
    // reset zeros look like an edge on every pin that idles high
    next_cur.warm      = (cur.warm == 2'h3) ? cur.warm : 2'(cur.warm + 2'h1);
    next_cur.edge_seen = ENABLE && (cur.warm == 2'h3) && (cur.sync2 != cur.last);
    if (ENABLE && regs.wr_data)
      next_cur.out = regs.wdata[WIDTH-1:0];
    if (ENABLE && regs.wr_hiz)
      next_cur.hiz = regs.wdata[WIDTH-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur.sync1     <= '0;
      cur.sync2     <= '0;
      cur.last      <= '0;
      cur.out       <= OUT_DEFAULT[WIDTH-1:0];
      cur.hiz       <= HIZ_DEFAULT[WIDTH-1:0];
      cur.warm      <= 2'h0;
      cur.edge_seen <= 1'b0;
    end
    else
      cur <= next_cur;
  end

  assign pins_out       = cur.out;
  assign pins_hiz       = cur.hiz;
  assign regs.edge_seen = cur.edge_seen;
  // Input bits read the pin, output bits read zero
  assign regs.rd_data   = ENABLE ? word_t'(cur.sync2 & cur.hiz) : '0;
  assign regs.rd_hiz    = ENABLE ? word_t'(cur.hiz) : '0;

endmodule

`default_nettype wire

// ===== rtl/gpio_port.sv
//
// Purpose: Dual channel GPIO port with APB register access and change interrupt
// Assumes: Single clock pclk; asynchronous pins synchronised inside channels
// Notes:   Unused registers read zero, writes to them are dropped
//
// What this block does
// - Host reaches all channel registers as 32-bit bus slave.
// - Interrupt output active high, level, held while pending, low from reset.
// - Channel 1 input pins sampled, width set by channel 1 parameter.
// - Channel 1 outputs driven, reset to configured default, normally zero.
// - Channel 1 per-bit high-impedance vector, reset default normally all ones.
// - Channel 2 inputs sampled at channel 2 width when second channel present.
// - Channel 2 outputs driven, reset to configured default, normally zero.
// - Channel 2 high-impedance vector, reset default normally all ones.
// - Output and direction reset values come from build-time parameters.
// - Set high-impedance bit means input, cleared bit means output.
// - With interrupts built in, any input transition flags channel event; channel 2 only when second channel present.
//
`timescale 1ns/100ps
`default_nettype none

`include "gpio_defs.svh"

module gpio_port
#(
  parameter int                    CH1_WIDTH       = 32,
  parameter int                    ch2_width_param = 32,
  parameter bit                    DUAL_CHANNEL    = 1'b0,
  parameter bit                    IRQ_ENABLE      = 1'b0,
  parameter logic [`MAX_WIDTH-1:0] CH1_OUT_DEFAULT = `RESET_OUT_DEFAULT,
  parameter logic [`MAX_WIDTH-1:0] CH1_HIZ_DEFAULT = `RESET_HIZ_DEFAULT,
  parameter logic [`MAX_WIDTH-1:0] CH2_OUT_DEFAULT = `RESET_OUT_DEFAULT,
  parameter logic [`MAX_WIDTH-1:0] CH2_HIZ_DEFAULT = `RESET_HIZ_DEFAULT
)
(
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire gpio_pkg::addr_t            paddr,
  input  wire gpio_pkg::word_t            pwdata,
  output var  gpio_pkg::word_t            prdata,
  output var  logic                       pready,
  output var  logic                       pslverr,
  // Interrupt
  output var  logic                       interrupt_request_out,
  // Channel 1 pins
  input  wire logic [CH1_WIDTH-1:0]       ch1_pins_in,
  output var  logic [CH1_WIDTH-1:0]       ch1_pins_out,
  output var  logic [CH1_WIDTH-1:0]       ch1_pins_hiz,
  // Channel 2 pins
  input  wire logic [ch2_width_param-1:0] ch2_pins_in,
  output var  logic [ch2_width_param-1:0] ch2_pins_out,
  output var  logic [ch2_width_param-1:0] ch2_pins_hiz
);
  import gpio_pkg::*;

  // Refuse widths the 32-bit register word cannot carry
  if (CH1_WIDTH < 1 || CH1_WIDTH > `MAX_WIDTH)
  begin
    $error("channel 1 width must be 1 to 32");
  end
  if (ch2_width_param < 1 || ch2_width_param > `MAX_WIDTH)
  begin
    $error("channel 2 width must be 1 to 32");
  end

  ////////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    word_t      rdata;
    logic       ready;
    logic       global_en;
    logic [1:0] irq_en;
    logic [1:0] irq_status;
    logic       irq;
  } top_s;

  top_s cur;
  top_s next_cur;

  gpio_chan_if ch1_bus ();
  gpio_chan_if ch2_bus ();

  ////////////////////////////////////////////////////////////////////////////////
  // Channels

  gpio_channel
  #(
    .WIDTH       (CH1_WIDTH),
    .ENABLE      (1'b1),
    .OUT_DEFAULT (CH1_OUT_DEFAULT),
    .HIZ_DEFAULT (CH1_HIZ_DEFAULT)
  )
  u_ch1
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .regs     (ch1_bus.chan),
    .pins_in  (ch1_pins_in),
    .pins_out (ch1_pins_out),
    .pins_hiz (ch1_pins_hiz)
  );

  // Single channel build keeps channel 2 at its reset defaults
  gpio_channel
  #(
    .WIDTH       (ch2_width_param),
    .ENABLE      (DUAL_CHANNEL),
    .OUT_DEFAULT (CH2_OUT_DEFAULT),
    .HIZ_DEFAULT (CH2_HIZ_DEFAULT)
  )
  u_ch2
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .regs     (ch2_bus.chan),
    .pins_in  (ch2_pins_in),
    .pins_out (ch2_pins_out),
    .pins_hiz (ch2_pins_hiz)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic  access;
  logic  wr;
  word_t rd_mux;

  // Answer one cycle after the access phase opens; ready clears it next cycle
  assign access = psel && penable && !cur.ready;
  assign wr     = access && pwrite;

  assign ch1_bus.wdata   = pwdata;
  assign ch2_bus.wdata   = pwdata;
  assign ch1_bus.wr_data = wr && (paddr == `REG_CH1_DATA);
  assign ch1_bus.wr_hiz  = wr && (paddr == `REG_CH1_HIZ);
  assign ch2_bus.wr_data = wr && (paddr == `REG_CH2_DATA);
  assign ch2_bus.wr_hiz  = wr && (paddr == `REG_CH2_HIZ);

  always_comb
  begin
    rd_mux = '0;
    if (paddr == `REG_CH1_DATA)
      rd_mux = ch1_bus.rd_data;
    else if (paddr == `REG_CH1_HIZ)
      rd_mux = ch1_bus.rd_hiz;
    else if (paddr == `REG_CH2_DATA)
      rd_mux = ch2_bus.rd_data;
    else if (paddr == `REG_CH2_HIZ)
      rd_mux = ch2_bus.rd_hiz;
    else if (IRQ_ENABLE && paddr == `REG_GLOBAL_IRQ_EN)
      rd_mux[`IRQ_GLOBAL_BIT] = cur.global_en;
    else if (IRQ_ENABLE && paddr == `REG_IRQ_STATUS)
      rd_mux[1:0] = cur.irq_status;
    else if (IRQ_ENABLE && paddr == `REG_IRQ_ENABLE)
      rd_mux[1:0] = cur.irq_en;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and interrupt

  logic [1:0] events;
  logic [1:0] toggle;

  assign events = IRQ_ENABLE ? {ch2_bus.edge_seen, ch1_bus.edge_seen} : 2'h0;
  assign toggle = (wr && IRQ_ENABLE && paddr == `REG_IRQ_STATUS) ? pwdata[1:0] : 2'h0;

  always_comb
  begin
    next_cur       = cur;
    next_cur.ready = access;
    if (access && !pwrite)
      next_cur.rdata = rd_mux;
    if (wr && IRQ_ENABLE && paddr == `REG_GLOBAL_IRQ_EN)
      next_cur.global_en = pwdata[`IRQ_GLOBAL_BIT];
    if (wr && IRQ_ENABLE && paddr == `REG_IRQ_ENABLE)
      next_cur.irq_en = pwdata[1:0];
    // Toggle on write, but a new event always leaves its bit set
    next_cur.irq_status = (cur.irq_status ^ toggle) | events;
    next_cur.irq = cur.global_en && |(cur.irq_status & cur.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign prdata                = cur.rdata;
  assign pready                = cur.ready;
  assign pslverr               = 1'b0;
  assign interrupt_request_out = cur.irq;

endmodule

`default_nettype wire

// ===== dv/gpio_port_props.sv
// Purpose: Port checks for gpio_port
// Assumes: Single pclk domain, presetn async active low
// Notes:   Bound to every gpio_port instance at the foot
`timescale 1ns/100ps
`default_nettype none
module gpio_port_props
  import gpio_pkg::*;
#(
  parameter int          CH1_WIDTH       = 32,
  parameter int          ch2_width_param = 32,
  parameter logic [31:0] CH1_OUT_DEFAULT = 32'h00000000,
  parameter logic [31:0] CH1_HIZ_DEFAULT = 32'hFFFFFFFF,
  parameter logic [31:0] CH2_OUT_DEFAULT = 32'h00000000,
  parameter logic [31:0] CH2_HIZ_DEFAULT = 32'hFFFFFFFF
)
(
  // Clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // Bus
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire gpio_pkg::addr_t            paddr,
  input wire gpio_pkg::word_t            pwdata,
  input wire gpio_pkg::word_t            prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // Pins
  input wire logic                       interrupt_request_out,
  input wire logic [CH1_WIDTH-1:0]       ch1_pins_in,
  input wire logic [CH1_WIDTH-1:0]       ch1_pins_out,
  input wire logic [CH1_WIDTH-1:0]       ch1_pins_hiz,
  input wire logic [ch2_width_param-1:0] ch2_pins_in,
  input wire logic [ch2_width_param-1:0] ch2_pins_out,
  input wire logic [ch2_width_param-1:0] ch2_pins_hiz
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && !pready; endsequence
  sequence taken_s; psel && penable && pready && pwrite; endsequence
  ready_time_a: assert property (setup_s ##1 access_s |=> pready)
    else $error("pready not two cycles after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> psel && penable)
    else $error("pready without access");
  slverr_zero_a: assert property (!pslverr)
    else $error("pslverr raised");
  reset_ch1_a: assert property ($rose(presetn) |-> ch1_pins_out == CH1_OUT_DEFAULT[CH1_WIDTH-1:0]
    && ch1_pins_hiz == CH1_HIZ_DEFAULT[CH1_WIDTH-1:0])
    else $error("channel 1 reset state wrong");
  reset_ch2_a: assert property ($rose(presetn) |->
    ch2_pins_out == CH2_OUT_DEFAULT[ch2_width_param-1:0]
    && ch2_pins_hiz == CH2_HIZ_DEFAULT[ch2_width_param-1:0])
    else $error("channel 2 reset state wrong");
  reset_irq_a: assert property ($rose(presetn) |-> !interrupt_request_out && !pready)
    else $error("irq or pready high out of reset");
  data_write_a: assert property (taken_s ##0 paddr == 12'h000
    |-> ch1_pins_out == pwdata[CH1_WIDTH-1:0])
    else $error("channel 1 outputs not written");
  hiz_write_a: assert property (taken_s ##0 paddr == 12'h004
    |-> ch1_pins_hiz == pwdata[CH1_WIDTH-1:0])
    else $error("channel 1 direction not written");
  ch2_write_a: assert property (taken_s ##0 paddr == 12'h008
    |-> ch2_pins_out == pwdata[ch2_width_param-1:0])
    else $error("channel 2 outputs not written");
  irq_hold_a: assert property (interrupt_request_out && !psel |=> interrupt_request_out)
    else $error("irq dropped without a write");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind gpio_port gpio_port_props #(.CH1_WIDTH(CH1_WIDTH), .ch2_width_param(ch2_width_param),
  .CH1_OUT_DEFAULT(CH1_OUT_DEFAULT), .CH1_HIZ_DEFAULT(CH1_HIZ_DEFAULT),
  .CH2_OUT_DEFAULT(CH2_OUT_DEFAULT), .CH2_HIZ_DEFAULT(CH2_HIZ_DEFAULT))
  gpio_port_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .interrupt_request_out(interrupt_request_out),
  .ch1_pins_in(ch1_pins_in), .ch1_pins_out(ch1_pins_out), .ch1_pins_hiz(ch1_pins_hiz),
  .ch2_pins_in(ch2_pins_in), .ch2_pins_out(ch2_pins_out), .ch2_pins_hiz(ch2_pins_hiz));
`default_nettype wire

// ===== dv/pin_partner.sv
// Purpose: Board-side model of one channel's pins
// Assumes: Far side drives only pins the device has released
// Notes:   Resolves the wire level fed back to the inputs
`timescale 1ns/100ps
`default_nettype none
module pin_partner
#(
  parameter int W = 8
)
(
  // Device side
  input  wire logic [W-1:0] pins_out,
  input  wire logic [W-1:0] pins_hiz,
  // Far side
  input  wire logic [W-1:0] ext_drive,
  output var  logic [W-1:0] pins_in
);
  // A cleared hiz bit means the device owns the wire
  always_comb pins_in = (pins_out & ~pins_hiz) | (ext_drive & pins_hiz);
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for gpio_port
// Assumes: Dual channel, interrupts built in, 8 and 4 bit channels
// Notes:   Channel 1 uses non-default reset values
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import gpio_pkg::*;
  localparam int    W1   = 8;
  localparam int    W2   = 4;
  localparam word_t OUT1 = 32'h000000A5;
  localparam word_t HIZ1 = 32'h0000000F;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  addr_t         paddr;
  word_t         pwdata, prdata, rd, hz, dv, ev;
  logic [7:0]    in1, out1, hiz1, ext1;
  logic [3:0]    in2, out2, hiz2, ext2;
  int            failures, num_checks, seed, ch;
  gpio_port #(.CH1_WIDTH(W1), .ch2_width_param(W2), .DUAL_CHANNEL(1'b1), .IRQ_ENABLE(1'b1),
    .CH1_OUT_DEFAULT(OUT1), .CH1_HIZ_DEFAULT(HIZ1)) gpio_port_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .interrupt_request_out(irq), .ch1_pins_in(in1), .ch1_pins_out(out1),
    .ch1_pins_hiz(hiz1), .ch2_pins_in(in2), .ch2_pins_out(out2), .ch2_pins_hiz(hiz2));
  pin_partner #(.W(W1)) pin_partner_inst (.pins_out(out1), .pins_hiz(hiz1),
    .ext_drive(ext1), .pins_in(in1));
  pin_partner #(.W(W2)) pin_partner_ch2_inst (.pins_out(out2), .pins_hiz(hiz2),
    .ext_drive(ext2), .pins_in(in2));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  function automatic word_t mask(input int c);
    return c ? 32'h0000000F : 32'h000000FF;
  endfunction
  task automatic check(input string name, input word_t exp, input word_t got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  // Request stands until pready is seen high at a rising edge; read data is taken there.
  // No cycle count is assumed: only the watchdog ends a wait that never answers.
  task automatic apb(input logic wr, input addr_t a, input word_t d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    check("pslverr", 32'h0, word_t'(pslverr));
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_irq(input int lim);
    int n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(negedge pclk);
      n++;
    end
  endtask
  task automatic toggle(input int c);
    @(posedge pclk);
    if (c)
      ext2 <= ext2 ^ 4'h1;
    else
      ext1 <= ext1 ^ 8'h01;
  endtask
  task automatic check_defaults();
    check("ch1_out", OUT1, word_t'(out1));
    check("ch1_hiz", HIZ1, word_t'(hiz1));
    check("ch2_out", 32'h0, word_t'(out2));
    check("ch2_hiz", 32'hF, word_t'(hiz2));
    check("irq", 32'h0, word_t'(irq));
  endtask
  task automatic final_report();
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    final_report();
  end
  initial
  begin
    seed = 32'h1ff2;
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ext1 = 8'h00;
    ext2 = 4'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check_defaults();
    for (int i = 0; i < 16; i++)
    begin
      ch = i % 2;
      hz = $random(seed);
      dv = $random(seed);
      ev = $random(seed);
      // First rounds pin all-output and all-input corners
      if (i < 2)
        hz = 32'h0;
      else if (i < 4)
        hz = 32'hFFFFFFFF;
      apb(1'b1, addr_t'(ch * 8 + 4), hz);
      apb(1'b1, addr_t'(ch * 8), dv);
      if (ch)
        ext2 <= ev[3:0];
      else
        ext1 <= ev[7:0];
      check("pins_out", dv & mask(ch), ch ? word_t'(out2) : word_t'(out1));
      check("pins_hiz", hz & mask(ch), ch ? word_t'(hiz2) : word_t'(hiz1));
      repeat (3) @(posedge pclk);
      apb(1'b0, addr_t'(ch * 8), 32'h0);
      check("data_read", hz & ev & mask(ch), rd);
    end
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped", 32'h0, rd);
    apb(1'b1, 12'h004, 32'hFF);
    apb(1'b1, 12'h00C, 32'hF);
    apb(1'b1, 12'h11C, 32'h80000000);
    apb(1'b1, 12'h128, 32'h3);
    apb(1'b0, 12'h120, 32'h0);
    apb(1'b1, 12'h120, rd);
    repeat (3) @(negedge pclk);
    check("irq_clear", 32'h0, word_t'(irq));
    toggle(0);
    wait_irq(20);
    check("irq_ch1", 32'h1, word_t'(irq));
    apb(1'b0, 12'h120, 32'h0);
    check("status", 32'h1, rd & 32'h3);
    apb(1'b1, 12'h120, 32'h1);
    repeat (3) @(negedge pclk);
    check("irq_ack", 32'h0, word_t'(irq));
    apb(1'b1, 12'h128, 32'h2);
    toggle(0);
    wait_irq(10);
    check("irq_masked", 32'h0, word_t'(irq));
    toggle(1);
    wait_irq(20);
    check("irq_ch2", 32'h1, word_t'(irq));
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    check_defaults();
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    check("hiz_reg", HIZ1, rd);
    apb(1'b0, 12'h120, 32'h0);
    check("status_reset", 32'h0, rd);
    final_report();
  end
endmodule
`default_nettype wire
